// File: rtl/brake_seq_pkg.sv
// Constants, register map and types of the holding brake sequencer
package brake_seq_pkg;
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned DATA_W         = 32;
   localparam int unsigned VAL_W          = 16;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL        = 8'h00;
   localparam logic [7:0] OFS_REL_FREQ    = 8'h04;
   localparam logic [7:0] OFS_REL_DWELL   = 8'h08;
   localparam logic [7:0] OFS_DWELL_ILIM  = 8'h0C;
   localparam logic [7:0] OFS_ENG_FREQ    = 8'h10;
   localparam logic [7:0] OFS_ENG_DELAY   = 8'h14;
   localparam logic [7:0] OFS_ENG_HOLD    = 8'h18;
   localparam logic [7:0] OFS_REL_TORQ    = 8'h1C;
   localparam logic [7:0] OFS_STATUS      = 8'h20;
   // Field positions
   localparam int unsigned CTRL_EN_BIT    = 0;
   localparam int unsigned ST_STATE_LSB   = 0;
   localparam int unsigned ST_RELEASE_BIT = 4;
   localparam int unsigned ST_BLOCK_BIT   = 5;
   localparam int unsigned ST_ILIM_BIT    = 6;
   // Reset values: frequency 0.01 Hz, time 0.1 s, current/torque 0.1 %
   localparam logic [VAL_W-1:0] RST_REL_FREQ   = 16'h00FA;
   localparam logic [VAL_W-1:0] RST_REL_DWELL  = 16'h000A;
   localparam logic [VAL_W-1:0] RST_DWELL_ILIM = 16'h04B0;
   localparam logic [VAL_W-1:0] RST_ENG_FREQ   = 16'h0096;
   localparam logic [VAL_W-1:0] RST_ENG_DELAY  = 16'h0000;
   localparam logic [VAL_W-1:0] RST_ENG_HOLD   = 16'h000A;
   localparam logic [VAL_W-1:0] RST_REL_TORQ   = 16'h0032;
   // Setting limits
   localparam logic [VAL_W-1:0] MAX_FREQ       = 16'h07D0;
   localparam logic [VAL_W-1:0] MAX_TIME       = 16'h00C8;
   localparam logic [VAL_W-1:0] MIN_ILIM       = 16'h01F4;
   localparam logic [VAL_W-1:0] MAX_ILIM       = 16'h07D0;
   localparam logic [VAL_W-1:0] MAX_TORQ       = 16'h03E8;
   // Timer tick
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned TICK_TIME_NS   = 100_000_000;
   localparam int unsigned TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      ST_STOPPED,
      ST_BYPASS,
      ST_ACCEL_REL,
      ST_WAIT_TORQ,
      ST_DWELL,
      ST_RUN,
      ST_DECEL_ENG,
      ST_ENG_DELAY,
      ST_ENG_HOLD
   } seq_state_t;
endpackage : brake_seq_pkg

// File: rtl/brake_tick_timer.sv
// Countdown of 0.1 s ticks, restarted on every load
`timescale 1ns/1ps
module brake_tick_timer #(
   parameter int unsigned TickCycles = brake_seq_pkg::TICK_CYCLES
) (
   input  wire logic      ref_clk,
   input  wire logic      reset,
   brake_timer_if.timer   tmr
);
   typedef struct packed {
      logic [31:0] prescale;
      logic [15:0] ticks;
      logic        done;
   } timer_state_t;

   timer_state_t cur_q;
   timer_state_t cur_d;

   always_comb
   begin
      cur_d = cur_q;
      // Prescaler restarts on load so each delay is whole ticks, not a partial first one
      if (tmr.load)
      begin
         cur_d.prescale = 32'h0000_0000;
         cur_d.ticks    = tmr.loadTicks;
         cur_d.done     = 1'b0;
      end
      else if (cur_q.ticks == 16'h0000)
      begin
         cur_d.done = 1'b1;
      end
      else if (cur_q.prescale == 32'(TickCycles - 1))
      begin
         cur_d.prescale = 32'h0000_0000;
         cur_d.ticks    = cur_q.ticks - 16'h0001;
      end
      else
      begin
         cur_d.prescale = cur_q.prescale + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cur_q <= '0;
      end
      else
      begin
         cur_q <= cur_d;
      end
   end

   // Not masked by load: a state that reloads on done would otherwise loop through it
   assign tmr.done = cur_q.done;
endmodule : brake_tick_timer

// File: rtl/brake_timer_if.sv
// Load and done handshake between sequencer and tick timer
`timescale 1ns/1ps
interface brake_timer_if;
   logic        load;
   logic [15:0] loadTicks;
   logic        done;
   modport ctrl  (output load, output loadTicks, input done);
   modport timer (input load, input loadTicks, output done);
endinterface : brake_timer_if

// File: rtl/holding_brake_sequencer.sv
// Holding brake sequencer with APB register access
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
//
// Function
// - One enable bit turns sequencing on
// - Run ramps only to release frequency
// - Release output asserted at release frequency
// - Hold release frequency for dwell time
// - Clamp current from release frequency until accelerating
// - Stop decelerates to engage frequency, holds
// - Wait engage delay, then drop release
// - Hold engage time, then block output
// - Release only while torque exceeds threshold
module holding_brake_sequencer #(
   parameter int unsigned TickCycles = brake_seq_pkg::TICK_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        runCmd,
   input  wire logic [15:0] setFrequency,
   input  wire logic [15:0] outputFrequency,
   input  wire logic [15:0] torqueCurrent,
   output logic      [15:0] targetFrequency,
   output logic             brakeRelease,
   output logic             currentLimitActive,
   output logic      [15:0] currentLimit,
   output logic             outputBlock
);
   typedef struct packed {
      logic                           runMeta;
      logic                           runSync;
      logic                           enable;
      logic [15:0]                    relFreq;
      logic [15:0]                    relDwell;
      logic [15:0]                    dwellIlim;
      logic [15:0]                    engFreq;
      logic [15:0]                    engDelay;
      logic [15:0]                    engHold;
      logic [15:0]                    relTorq;
      brake_seq_pkg::seq_state_t      state;
      logic [15:0]                    target;
      logic                           release_;
      logic                           ilimOn;
      logic                           block;
      logic [31:0]                    rdata;
      logic                           err;
   } seq_reg_t;

   seq_reg_t    cur_q;
   seq_reg_t    cur_d;
   logic        setupPhase;
   logic        mapped;
   logic [15:0] wval;
   logic        torqueOk;

   brake_timer_if tmrBus ();

   brake_tick_timer #(
      .TickCycles (TickCycles)
   ) u_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .tmr     (tmrBus)
   );

   function automatic logic [15:0] clampHi(input logic [15:0] v, input logic [15:0] hi);
      clampHi = (v > hi) ? hi : v;
   endfunction : clampHi

   assign setupPhase = psel & ~penable;
   assign wval       = pwdata[15:0];
   assign mapped     = (paddr[1:0] == 2'b00) && (paddr <= brake_seq_pkg::OFS_STATUS);
   // A zero threshold switches the torque check off
   assign torqueOk   = (cur_q.relTorq == 16'h0000) || (torqueCurrent > cur_q.relTorq);

   always_comb
   begin
      cur_d         = cur_q;
      cur_d.runMeta = runCmd;
      cur_d.runSync = cur_q.runMeta;
      tmrBus.load      = 1'b0;
      tmrBus.loadTicks = 16'h0000;

      // Register access; reads captured in setup so access completes without waits
      if (setupPhase)
      begin
         cur_d.err   = ~mapped;
         cur_d.rdata = 32'h0000_0000;
         case (paddr)
            brake_seq_pkg::OFS_CTRL:       cur_d.rdata[brake_seq_pkg::CTRL_EN_BIT] = cur_q.enable;
            brake_seq_pkg::OFS_REL_FREQ:   cur_d.rdata[15:0] = cur_q.relFreq;
            brake_seq_pkg::OFS_REL_DWELL:  cur_d.rdata[15:0] = cur_q.relDwell;
            brake_seq_pkg::OFS_DWELL_ILIM: cur_d.rdata[15:0] = cur_q.dwellIlim;
            brake_seq_pkg::OFS_ENG_FREQ:   cur_d.rdata[15:0] = cur_q.engFreq;
            brake_seq_pkg::OFS_ENG_DELAY:  cur_d.rdata[15:0] = cur_q.engDelay;
            brake_seq_pkg::OFS_ENG_HOLD:   cur_d.rdata[15:0] = cur_q.engHold;
            brake_seq_pkg::OFS_REL_TORQ:   cur_d.rdata[15:0] = cur_q.relTorq;
            brake_seq_pkg::OFS_STATUS:
            begin
               cur_d.rdata[brake_seq_pkg::ST_STATE_LSB +: 4]     = cur_q.state;
               cur_d.rdata[brake_seq_pkg::ST_RELEASE_BIT]        = cur_q.release_;
               cur_d.rdata[brake_seq_pkg::ST_BLOCK_BIT]          = cur_q.block;
               cur_d.rdata[brake_seq_pkg::ST_ILIM_BIT]           = cur_q.ilimOn;
            end
            default: cur_d.rdata = 32'h0000_0000;
         endcase
      end

      // Out-of-range settings saturate at the nearest limit
      if (psel && penable && pwrite && !cur_q.err)
      begin
         case (paddr)
            brake_seq_pkg::OFS_CTRL:       cur_d.enable   = pwdata[brake_seq_pkg::CTRL_EN_BIT];
            brake_seq_pkg::OFS_REL_FREQ:   cur_d.relFreq  = clampHi(wval, brake_seq_pkg::MAX_FREQ);
            brake_seq_pkg::OFS_REL_DWELL:  cur_d.relDwell = clampHi(wval, brake_seq_pkg::MAX_TIME);
            brake_seq_pkg::OFS_DWELL_ILIM:
               cur_d.dwellIlim = (wval < brake_seq_pkg::MIN_ILIM) ? brake_seq_pkg::MIN_ILIM
                                                                 : clampHi(wval, brake_seq_pkg::MAX_ILIM);
            brake_seq_pkg::OFS_ENG_FREQ:   cur_d.engFreq  = clampHi(wval, brake_seq_pkg::MAX_FREQ);
            brake_seq_pkg::OFS_ENG_DELAY:  cur_d.engDelay = clampHi(wval, brake_seq_pkg::MAX_TIME);
            brake_seq_pkg::OFS_ENG_HOLD:   cur_d.engHold  = clampHi(wval, brake_seq_pkg::MAX_TIME);
            brake_seq_pkg::OFS_REL_TORQ:   cur_d.relTorq  = clampHi(wval, brake_seq_pkg::MAX_TORQ);
            default: ;
         endcase
      end

      case (cur_q.state)
         brake_seq_pkg::ST_STOPPED:
         begin
            cur_d.target   = 16'h0000;
            cur_d.release_ = 1'b0;
            cur_d.ilimOn   = 1'b0;
            cur_d.block    = 1'b1;
            if (cur_q.runSync)
            begin
               cur_d.block = 1'b0;
               cur_d.state = cur_q.enable ? brake_seq_pkg::ST_ACCEL_REL : brake_seq_pkg::ST_BYPASS;
            end
         end
         brake_seq_pkg::ST_BYPASS:
         begin
            cur_d.target = setFrequency;
            if (!cur_q.runSync)
            begin
               cur_d.state = brake_seq_pkg::ST_STOPPED;
            end
         end
         brake_seq_pkg::ST_ACCEL_REL:
         begin
            cur_d.target = cur_q.relFreq;
            if (!cur_q.runSync)
            begin
               cur_d.state = brake_seq_pkg::ST_DECEL_ENG;
            end
            else if (outputFrequency >= cur_q.relFreq)
            begin
               cur_d.state  = brake_seq_pkg::ST_WAIT_TORQ;
               cur_d.ilimOn = 1'b1;
            end
         end
         brake_seq_pkg::ST_WAIT_TORQ:
         begin
            // Brake stays closed until the motor really carries torque
            if (!cur_q.runSync)
            begin
               cur_d.state  = brake_seq_pkg::ST_DECEL_ENG;
               cur_d.ilimOn = 1'b0;
            end
            else if (torqueOk)
            begin
               cur_d.release_   = 1'b1;
               cur_d.state      = brake_seq_pkg::ST_DWELL;
               tmrBus.load      = 1'b1;
               tmrBus.loadTicks = cur_q.relDwell;
            end
         end
         brake_seq_pkg::ST_DWELL:
         begin
            cur_d.release_ = torqueOk;
            if (!cur_q.runSync)
            begin
               cur_d.ilimOn = 1'b0;
               cur_d.state  = brake_seq_pkg::ST_DECEL_ENG;
            end
            else if (tmrBus.done)
            begin
               cur_d.ilimOn = 1'b0;
               cur_d.state  = brake_seq_pkg::ST_RUN;
            end
         end
         brake_seq_pkg::ST_RUN:
         begin
            cur_d.release_ = torqueOk;
            cur_d.target   = setFrequency;
            if (!cur_q.runSync)
            begin
               cur_d.state = brake_seq_pkg::ST_DECEL_ENG;
            end
         end
         brake_seq_pkg::ST_DECEL_ENG:
         begin
            cur_d.release_ = cur_q.release_ & torqueOk;
            cur_d.target   = cur_q.engFreq;
            if (outputFrequency <= cur_q.engFreq)
            begin
               cur_d.state      = brake_seq_pkg::ST_ENG_DELAY;
               tmrBus.load      = 1'b1;
               tmrBus.loadTicks = cur_q.engDelay;
            end
         end
         brake_seq_pkg::ST_ENG_DELAY:
         begin
            cur_d.release_ = cur_q.release_ & torqueOk;
            if (tmrBus.done)
            begin
               cur_d.release_   = 1'b0;
               cur_d.state      = brake_seq_pkg::ST_ENG_HOLD;
               tmrBus.load      = 1'b1;
               tmrBus.loadTicks = cur_q.engHold;
            end
         end
         brake_seq_pkg::ST_ENG_HOLD:
         begin
            if (tmrBus.done)
            begin
               cur_d.block  = 1'b1;
               cur_d.target = 16'h0000;
               cur_d.state  = brake_seq_pkg::ST_STOPPED;
            end
         end
         default:
         begin
            cur_d.state = brake_seq_pkg::ST_STOPPED;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cur_q           <= '0;
         cur_q.state     <= brake_seq_pkg::ST_STOPPED;
         cur_q.block     <= 1'b1;
         cur_q.relFreq   <= brake_seq_pkg::RST_REL_FREQ;
         cur_q.relDwell  <= brake_seq_pkg::RST_REL_DWELL;
         cur_q.dwellIlim <= brake_seq_pkg::RST_DWELL_ILIM;
         cur_q.engFreq   <= brake_seq_pkg::RST_ENG_FREQ;
         cur_q.engDelay  <= brake_seq_pkg::RST_ENG_DELAY;
         cur_q.engHold   <= brake_seq_pkg::RST_ENG_HOLD;
         cur_q.relTorq   <= brake_seq_pkg::RST_REL_TORQ;
      end
      else
      begin
         cur_q <= cur_d;
      end
   end

   assign prdata             = cur_q.rdata;
   assign pready             = 1'b1;
   assign pslverr            = psel & penable & cur_q.err;
   assign targetFrequency    = cur_q.target;
   assign brakeRelease       = cur_q.release_;
   assign currentLimitActive = cur_q.ilimOn;
   assign currentLimit       = cur_q.dwellIlim;
   assign outputBlock        = cur_q.block;
endmodule : holding_brake_sequencer

// File: tb/holding_brake_sequencer_properties.sv
// Port-level checker of the holding brake sequencer
`timescale 1ns/1ps
module holding_brake_sequencer_properties (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        runCmd,
   input wire logic [15:0] outputFrequency,
   input wire logic [15:0] torqueCurrent,
   input wire logic        brakeRelease,
   input wire logic        currentLimitActive,
   input wire logic        outputBlock
);
   logic [15:0] relFreq_q;
   logic [15:0] relTorq_q;
   logic        acc;
   logic        okAddr;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   assign acc    = psel && penable;
   assign okAddr = paddr[1:0] == 2'b00 && paddr <= brake_seq_pkg::OFS_STATUS;
   // Shadows saturate like the settings they follow
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         relFreq_q <= brake_seq_pkg::RST_REL_FREQ;
         relTorq_q <= brake_seq_pkg::RST_REL_TORQ;
      end
      else if (acc && pwrite && paddr == brake_seq_pkg::OFS_REL_FREQ)
         relFreq_q <= (pwdata[15:0] > brake_seq_pkg::MAX_FREQ) ? brake_seq_pkg::MAX_FREQ : pwdata[15:0];
      else if (acc && pwrite && paddr == brake_seq_pkg::OFS_REL_TORQ)
         relTorq_q <= (pwdata[15:0] > brake_seq_pkg::MAX_TORQ) ? brake_seq_pkg::MAX_TORQ : pwdata[15:0];
   end
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_error_bad_addr: assert property (acc && !okAddr |-> pslverr)
      else $error("no error on bad address");
   a_error_good_addr: assert property (acc && okAddr |-> !pslverr)
      else $error("error on mapped address");
   a_release_at_freq: assert property ($rose(brakeRelease) |-> outputFrequency >= relFreq_q)
      else $error("release below release frequency");
   a_release_torque_ok: assert property (brakeRelease |->
      $past(relTorq_q) == 16'h0000 || $past(torqueCurrent) > $past(relTorq_q))
      else $error("release without torque");
   a_release_with_limit: assert property ($rose(brakeRelease) |-> currentLimitActive)
      else $error("release without current clamp");
   a_block_no_release: assert property (outputBlock |-> !brakeRelease)
      else $error("release while blocked");
   a_block_no_limit: assert property (outputBlock |-> !currentLimitActive)
      else $error("clamp while blocked");
   a_run_unblocks: assert property ($rose(runCmd) && outputBlock |-> ##[1:6] !outputBlock)
      else $error("run did not start");
endmodule : holding_brake_sequencer_properties

bind holding_brake_sequencer holding_brake_sequencer_properties u_props (.*);

// File: tb/motor_brake_model.sv
// Motor and brake stand-in: ramps output frequency, reports torque
`timescale 1ns/1ps
module motor_brake_model #(
   parameter logic [15:0] Step = 16'h000A
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [15:0] targetFrequency,
   input  wire logic        outputBlock,
   input  wire logic [15:0] torqueLevel,
   output logic      [15:0] outputFrequency,
   output logic      [15:0] torqueCurrent
);
   // A blocked output carries no torque current
   assign torqueCurrent = outputBlock ? 16'h0000 : torqueLevel;
   always_ff @(posedge ref_clk)
   begin
      if (reset || outputBlock)
         outputFrequency <= 16'h0000;
      else if (outputFrequency + Step <= targetFrequency)
         outputFrequency <= outputFrequency + Step;
      else if (outputFrequency >= targetFrequency + Step)
         outputFrequency <= outputFrequency - Step;
      else
         outputFrequency <= targetFrequency;
   end
endmodule : motor_brake_model

// File: tb/test_holding_brake_sequencer.sv
// Random and directed bench of the holding brake sequencer
`timescale 1ns/1ps
module test_holding_brake_sequencer;
   localparam int Tick = 10;
   localparam logic [15:0] RV [9] = '{16'h0000, brake_seq_pkg::RST_REL_FREQ,
      brake_seq_pkg::RST_REL_DWELL, brake_seq_pkg::RST_DWELL_ILIM, brake_seq_pkg::RST_ENG_FREQ,
      brake_seq_pkg::RST_ENG_DELAY, brake_seq_pkg::RST_ENG_HOLD, brake_seq_pkg::RST_REL_TORQ, 16'h0020};
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        runCmd = 1'b0;
   logic [15:0] setFrequency = 16'h03E8;
   logic [15:0] torqueLevel = 16'h0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, brakeRelease, currentLimitActive, outputBlock;
   logic [15:0] outputFrequency, torqueCurrent, targetFrequency, currentLimit, rf, ef, il, v;
   logic [7:0]  a;
   int          fails = 0, cmp_count = 0, n, seed;
   holding_brake_sequencer #(.TickCycles(Tick)) DUT (.*);
   motor_brake_model motor (.*);
   always #10 ref_clk = ~ref_clk;
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic hang;
      fails++;
      conclude();
   endtask : hang
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Outputs read in the edge's own step, before the design's registers move
      @(posedge ref_clk);
      for (i = 0; i < 20 && pready !== 1'b1; i++)
         @(posedge ref_clk);
      if (pready !== 1'b1)
         hang();
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [15:0] lim(input logic [15:0] x, input logic [15:0] m);
      return (x > m) ? m : x;
   endfunction : lim
   function automatic logic [31:0] expRd(input logic [7:0] ad, input logic [15:0] x);
      case (ad)
         8'h00: return {31'h0000_0000, x[0]};
         8'h04, 8'h10: return {16'h0000, lim(x, brake_seq_pkg::MAX_FREQ)};
         8'h0C: return {16'h0000, lim((x < brake_seq_pkg::MIN_ILIM) ? brake_seq_pkg::MIN_ILIM : x,
                                      brake_seq_pkg::MAX_ILIM)};
         8'h1C: return {16'h0000, lim(x, brake_seq_pkg::MAX_TORQ)};
         default: return {16'h0000, lim(x, brake_seq_pkg::MAX_TIME)};
      endcase
   endfunction : expRd
   function automatic bit cnd(input int s);
      case (s)
         0: return currentLimitActive === 1'b1;
         1: return brakeRelease === 1'b1;
         2: return currentLimitActive === 1'b0;
         3: return outputBlock === 1'b0;
         4: return outputBlock === 1'b1;
         5: return brakeRelease === 1'b0;
         default: return outputFrequency <= ef;
      endcase
   endfunction : cnd
   task automatic waitOn(input int s);
      for (n = 0; n < 400 && !cnd(s); n++)
         tick();
      if (!cnd(s))
         hang();
   endtask : waitOn
   initial
   begin
      seed = $urandom(72);
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0000_0000);
         chk("reset value", RV[i], rd);
      end
      for (int i = 0; i < 12; i++)
      begin
         a = 8'(($urandom % 8) * 4);
         v = 16'($urandom % 4096);
         apb(1'b1, a, {16'h0000, v});
         apb(1'b0, a, 32'h0000_0000);
         chk("readback", expRd(a, v), rd);
      end
      apb(1'b1, 8'h0C, 32'h0000_0001);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("limit floor", 32'h0000_01F4, rd);
      apb(1'b1, 8'h20, 32'h0000_0007);
      apb(1'b0, 8'h24, 32'h0000_0000);
      chk("unmapped", 1'b1, er);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("status", 32'h0000_0020, rd);
      $display("test registers done");
      apb(1'b1, 8'h00, 32'h0000_0000);
      setFrequency <= 16'(500 + $urandom % 1500);
      @(posedge ref_clk) runCmd <= 1'b1;
      waitOn(3);
      // Target follows one cycle after the unblock
      tick();
      chk("bypass target", setFrequency, targetFrequency);
      repeat (40) tick();
      chk("bypass release", 1'b0, brakeRelease);
      @(posedge ref_clk) runCmd <= 1'b0;
      waitOn(4);
      $display("test bypass done");
      rf = 16'(100 + $urandom % 400);
      ef = 16'(20 + $urandom % 60);
      il = 16'(500 + $urandom % 1500);
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b1, 8'h04, {16'h0000, rf});
      apb(1'b1, 8'h08, 32'h0000_0002);
      apb(1'b1, 8'h0C, {16'h0000, il});
      apb(1'b1, 8'h10, {16'h0000, ef});
      apb(1'b1, 8'h14, 32'h0000_0001);
      apb(1'b1, 8'h18, 32'h0000_0002);
      apb(1'b1, 8'h1C, 32'h0000_0032);
      @(posedge ref_clk) runCmd <= 1'b1;
      waitOn(0);
      chk("release target", rf, targetFrequency);
      chk("dwell limit", il, currentLimit);
      repeat (20) tick();
      chk("torque gate", 1'b0, brakeRelease);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("waiting status", 32'h0000_0043, rd);
      @(posedge ref_clk) torqueLevel <= 16'h0033;
      waitOn(1);
      waitOn(2);
      chk("dwell time", 1'b1, n >= 2 * Tick + 1 && n <= 2 * Tick + 2);
      tick();
      chk("run target", setFrequency, targetFrequency);
      @(posedge ref_clk) runCmd <= 1'b0;
      waitOn(6);
      chk("engage target", ef, targetFrequency);
      waitOn(5);
      chk("engage delay", 1'b1, n >= Tick + 1 && n <= Tick + 3);
      waitOn(4);
      chk("engage hold", 1'b1, n >= 2 * Tick + 1 && n <= 2 * Tick + 2);
      $display("test brake sequence done");
      conclude();
   end
endmodule : test_holding_brake_sequencer
